// ### alert_select_and_trim_regs.sv
// Alert-select masks, trim registers and combined alert output
//
// Behaviour
// RULE_01: Clamp trim holds an 8-bit code; each step raises threshold 3.1 mV.
// RULE_02: Power-up copies EEPROM 8118h and 8119h into clamp and output trims.
// RULE_03: Output level trim: 8-bit read/write target, set at calibration.
// RULE_04: Power-up copies EEPROM 811Ah and 811Bh into alert masks A and B.
// RULE_05: Alert pin asserts when any enabled flag in either mask is active.
// RULE_06: Mask A 7..0: OV, UV, OCP timeout, AC lost, OCP, OT, OR, share.
// RULE_07: Mask B: bit 7 supply, 6..3 monitors one-four, 1 monitor five.
// RULE_08: Mask B bit 2 lets the host drive the alert pin directly.
// RULE_09: Mask B bit 0 stores and reads back but never affects the alert.
// RULE_10: Alert recomputed every clock; drops once no enabled source remains.
`timescale 1ns/1ps

module alert_select_and_trim_regs
    import alert_trim_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           rst_n,
    input  wire reg_req_t       reg_req,
    input  wire ee_load_t       ee_load,
    input  wire fault_flags_t   fault_flags,
    input  wire monitor_flags_t monitor_flags,
    output logic [7:0]          rdata,
    output logic                rvalid,
    output logic [7:0]          uv_clamp_code,
    output logic [7:0]          output_level_code,
    output logic                combined_alert_pin
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] undervoltage_clamp_trim_reg;
    logic [7:0] undervoltage_clamp_trim_next;
    logic [7:0] output_level_trim_reg;
    logic [7:0] output_level_trim_next;
    logic [7:0] alert_mask_a_bits_reg;
    logic [7:0] alert_mask_a_bits_next;
    logic [7:0] alert_mask_b_bits_reg;
    logic [7:0] alert_mask_b_bits_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       rvalid_reg;
    logic       rvalid_next;
    logic       alert_reg;
    logic       alert_next;
    // Source vectors laid out bit for bit against the two masks
    logic [7:0] fault_vec;
    logic [7:0] mask_b_flags;

    // Software write to a given offset
    function automatic logic sw_hit(input reg_req_t r, input logic [7:0] ofs);
        sw_hit = r.wr_en && (r.addr == ofs);
    endfunction : sw_hit

    // EEPROM power-up copy to a given shadow address
    function automatic logic ee_hit(input ee_load_t e, input logic [15:0] a);
        ee_hit = e.load_en && (e.ee_addr == a);
    endfunction : ee_hit

    ////////////////////////////////////////////////////////////////////////
    // Trim next values. The EEPROM copy lands first and a host write may
    // follow at any time; when both hit one register in the same cycle the
    // host wins, since the copy runs once at power-up and the host value is
    // the newer intent. The codes leave here raw: the analog side turns the
    // clamp code into a threshold at a fixed step per count, so no scaling
    // is done in logic.
    always_comb begin
        undervoltage_clamp_trim_next = undervoltage_clamp_trim_reg;
        output_level_trim_next       = output_level_trim_reg;
        if (ee_hit(ee_load, UV_CLAMP_EE_ADDR)) begin
            undervoltage_clamp_trim_next = ee_load.ee_data; // see RULE_02
        end
        if (ee_hit(ee_load, OUTPUT_LVL_EE_ADDR)) begin
            output_level_trim_next = ee_load.ee_data; // see RULE_02
        end
        if (sw_hit(reg_req, UV_CLAMP_TRIM_OFS)) begin
            undervoltage_clamp_trim_next = reg_req.wdata; // see RULE_01
        end
        if (sw_hit(reg_req, OUTPUT_LVL_TRIM_OFS)) begin
            output_level_trim_next = reg_req.wdata; // see RULE_03
        end
    end

    // Trim registers; cleared on reset and idle until the EEPROM copy, so a
    // host read before the copy sees the reset value, not the stored trim
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            undervoltage_clamp_trim_reg <= TRIM_RESET_VALUE;
            output_level_trim_reg       <= TRIM_RESET_VALUE;
        end else begin
            undervoltage_clamp_trim_reg <= undervoltage_clamp_trim_next;
            output_level_trim_reg       <= output_level_trim_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask next values, same priority as the trims: host write over copy.
    // All eight bits of both masks are stored, the spare bit of mask B too,
    // so a host that reads back what it wrote never sees a mismatch.
    always_comb begin
        alert_mask_a_bits_next = alert_mask_a_bits_reg;
        alert_mask_b_bits_next = alert_mask_b_bits_reg;
        if (ee_hit(ee_load, ALERT_A_EE_ADDR)) begin
            alert_mask_a_bits_next = ee_load.ee_data; // see RULE_04
        end
        if (ee_hit(ee_load, ALERT_B_EE_ADDR)) begin
            alert_mask_b_bits_next = ee_load.ee_data; // see RULE_04
        end
        if (sw_hit(reg_req, ALERT_MASK_A_OFS)) begin
            alert_mask_a_bits_next = reg_req.wdata; // see RULE_06
        end
        if (sw_hit(reg_req, ALERT_MASK_B_OFS)) begin
            alert_mask_b_bits_next = reg_req.wdata; // see RULE_09
        end
    end

    // Mask registers; every enable is off until the copy lands, so the pin
    // stays quiet through reset even with faults already present. The cost
    // is that nothing is reported before the copy.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            alert_mask_a_bits_reg <= MASK_RESET_VALUE;
            alert_mask_b_bits_reg <= MASK_RESET_VALUE;
        end else begin
            alert_mask_a_bits_reg <= alert_mask_a_bits_next;
            alert_mask_b_bits_reg <= alert_mask_b_bits_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: one-cycle latency, unmapped offsets read zero. A read in
    // the same cycle as a write to the same offset returns the old value,
    // since the mux looks at the registers, not at their next values.
    always_comb begin
        rvalid_next = reg_req.rd_en;
        rdata_next  = rdata_reg;
        if (reg_req.rd_en) begin
            unique case (reg_req.addr)
                UV_CLAMP_TRIM_OFS:   rdata_next = undervoltage_clamp_trim_reg;
                OUTPUT_LVL_TRIM_OFS: rdata_next = output_level_trim_reg;
                ALERT_MASK_A_OFS:    rdata_next = alert_mask_a_bits_reg;
                ALERT_MASK_B_OFS:    rdata_next = alert_mask_b_bits_reg;
                default:             rdata_next = 8'h00;
            endcase
        end
    end

    // Read answer registers; rdata holds between reads so the host may pick
    // it up after rvalid has dropped
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg  <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault vector in mask A order. Flags come from same-clock logic, so no
    // synchroniser; built by name so a reordered flag struct cannot shift
    always_comb begin
        fault_vec               = 8'h00;
        fault_vec[FLAG_OV]      = fault_flags.overvoltage_fault;
        fault_vec[FLAG_UV]      = fault_flags.undervoltage_fault;
        fault_vec[FLAG_OCP_TO]  = fault_flags.ocp_timeout;
        fault_vec[FLAG_AC_LOST] = fault_flags.ac_sense_lost;
        fault_vec[FLAG_OCP]     = fault_flags.overcurrent_flag;
        fault_vec[FLAG_OTP]     = fault_flags.overtemperature;
        fault_vec[FLAG_ORSW]    = fault_flags.or_switch_fault;
        fault_vec[FLAG_SHARE]   = fault_flags.share_fault; // see RULE_06
    end

    // Monitor vector in mask B order. The host slot is a constant one, so
    // its enable alone drives the pin; the spare slot is a constant zero, so
    // whatever is stored there never reaches the pin.
    always_comb begin
        mask_b_flags                    = 8'h00;
        mask_b_flags[MASK_B_SUPPLY_BIT] = monitor_flags.supply_not_ok;
        mask_b_flags[MASK_B_MON1_BIT]   = monitor_flags.monitor_one_flag;
        mask_b_flags[MASK_B_MON2_BIT]   = monitor_flags.monitor_two_flag;
        mask_b_flags[MASK_B_MON3_BIT]   = monitor_flags.monitor_three_flag;
        mask_b_flags[MASK_B_MON4_BIT]   = monitor_flags.monitor_four_flag;
        mask_b_flags[MASK_B_HOST_BIT]   = 1'b1; // see RULE_08
        mask_b_flags[MASK_B_MON5_BIT]   = monitor_flags.monitor_five_flag;
        mask_b_flags[MASK_B_UNUSED_BIT] = 1'b0; // see RULE_09 see RULE_07
    end

    // Alert next value: any enabled source from either mask sets the pin
    always_comb begin
        alert_next = (|(alert_mask_a_bits_reg & fault_vec)) // see RULE_06
                   | (|(alert_mask_b_bits_reg & mask_b_flags)); // see RULE_05
    end

    // Alert register; re-evaluated every edge so the pin falls one cycle
    // after the last enabled source clears. The flop costs one cycle of lag
    // but keeps the pin free of glitches from the mask AND-OR tree, which a
    // host input might otherwise catch as a short alert.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            alert_reg <= 1'b0;
        end else begin
            alert_reg <= alert_next; // see RULE_10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops; the trim codes go out raw and the
    // analog side scales them
    assign rdata              = rdata_reg;
    assign rvalid             = rvalid_reg;
    assign uv_clamp_code      = undervoltage_clamp_trim_reg; // see RULE_01
    assign output_level_code  = output_level_trim_reg; // see RULE_03
    assign combined_alert_pin = alert_reg;

endmodule : alert_select_and_trim_regs

// ### alert_select_and_trim_regs_bench.sv
// Self-checking bench for the alert-select and trim register block
`timescale 1ns/1ps
module alert_select_and_trim_regs_bench;
    import alert_trim_pkg::*;
    logic ref_clk = 0, rst_n = 0, rvalid, pin;
    reg_req_t req = '0;
    ee_load_t ee = '0;
    logic [13:0] lvl = '0;
    fault_flags_t ff;
    monitor_flags_t mf;
    logic [7:0] rdata, uvc, olc, d[5], q[$];
    int failures = 0, n_tests = 0, seed = 32'h4347BD01, i;
    flag_source_model u_flag_source_model (.level(lvl), .fault_flags(ff),
        .monitor_flags(mf));
    alert_select_and_trim_regs u_alert_select_and_trim_regs (.ref_clk(ref_clk),
        .rst_n(rst_n), .reg_req(req), .ee_load(ee), .fault_flags(ff),
        .monitor_flags(mf), .rdata(rdata), .rvalid(rvalid),
        .uv_clamp_code(uvc), .output_level_code(olc), .combined_alert_pin(pin));
    initial forever #20 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] s, e, input string n);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task end_of_test;
        chk(8'(q.size()), 8'h00, "pending reads");
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    task wr(input logic [7:0] a, v);
        @(posedge ref_clk) req <= '{1'b1, 1'b0, a, v};
        @(posedge ref_clk) req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, e);
        @(posedge ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
        q.push_back(e);
        @(posedge ref_clk) req <= '0;
    endtask : rd
    task al(input logic [7:0] ma, mb, input logic [13:0] l, input logic e);
        @(posedge ref_clk) lvl <= l;
        wr(8'h1A, ma);
        wr(8'h1B, mb);
        // Mask B lands at the last write edge; the pin follows one edge on
        @(posedge ref_clk);
        @(negedge ref_clk) chk({7'h0, pin}, {7'h0, e}, "alert");
    endtask : al
    // Read answers are matched oldest first, away from the launching edge
    always @(negedge ref_clk) if (rvalid === 1'b1) begin
        if (q.size() == 0) chk({7'h0, rvalid}, 8'h00, "spare answer");
        else chk(rdata, q.pop_front(), "read data");
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        for (i = 0; i < 4; i++) rd(8'h18 + 8'(i), 8'h00);
        for (i = 0; i < 5; i++) begin
            d[i] = 8'($random(seed));
            @(posedge ref_clk) ee <= '{1'b1, 16'h8118 + 16'(i), d[i]};
            @(posedge ref_clk) ee <= '0;
        end
        for (i = 0; i < 4; i++) rd(8'h18 + 8'(i), d[i]);
        $display("power-up copy test done");
        for (i = 0; i < 4; i++) begin
            d[i] = 8'($random(seed));
            wr(8'h18 + 8'(i), d[i]);
        end
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'h00);
        for (i = 0; i < 4; i++) rd(8'h18 + 8'(i), d[i]);
        chk(uvc, d[0], "clamp code");
        chk(olc, d[1], "level code");
        @(posedge ref_clk) begin
            req <= '{1'b1, 1'b0, 8'h19, 8'h5A};
            ee <= '{1'b1, 16'h8119, 8'hA5};
        end
        @(posedge ref_clk) begin
            req <= '0;
            ee <= '0;
        end
        rd(8'h19, 8'h5A);
        $display("register access test done");
        for (i = 0; i < 8; i++) begin
            al(8'h01 << i, 8'h00, 14'h0040 << i, 1'b1);
            al(~(8'h01 << i), 8'h00, 14'h0040 << i, 1'b0);
        end
        for (i = 0; i < 6; i++) al(8'h00, 8'h01 << (i > 0 ? i + 2 : 1),
            14'h0001 << i, 1'b1);
        al(8'h00, 8'h04, 14'h0000, 1'b1);
        al(8'h00, 8'h01, 14'h3FFF, 1'b0);
        al(8'hFF, 8'hFB, 14'h3FFF, 1'b1);
        al(8'hFF, 8'hFB, 14'h0000, 1'b0);
        $display("alert test done");
        end_of_test;
    end
endmodule : alert_select_and_trim_regs_bench

// ### alert_trim_pkg.sv
// Package for the alert-select and trim register block
package alert_trim_pkg;

    // Register offsets on the internal register port
    localparam logic [7:0] UV_CLAMP_TRIM_OFS   = 8'h18;
    localparam logic [7:0] OUTPUT_LVL_TRIM_OFS = 8'h19;
    localparam logic [7:0] ALERT_MASK_A_OFS    = 8'h1A;
    localparam logic [7:0] ALERT_MASK_B_OFS    = 8'h1B;

    // EEPROM shadow addresses copied at power-up
    localparam logic [15:0] UV_CLAMP_EE_ADDR   = 16'h8118;
    localparam logic [15:0] OUTPUT_LVL_EE_ADDR = 16'h8119;
    localparam logic [15:0] ALERT_A_EE_ADDR    = 16'h811A;
    localparam logic [15:0] ALERT_B_EE_ADDR    = 16'h811B;

    // Values held until the EEPROM copy lands
    localparam logic [7:0] TRIM_RESET_VALUE = 8'h00;
    localparam logic [7:0] MASK_RESET_VALUE = 8'h00;

    // Clamp step per code unit, in microvolts
    localparam int UV_CLAMP_STEP_UV = 3100;

    // Mask B field positions
    localparam int MASK_B_HOST_BIT   = 2;
    localparam int MASK_B_UNUSED_BIT = 0;
    localparam int MASK_B_SUPPLY_BIT = 7;
    localparam int MASK_B_MON1_BIT   = 6;
    localparam int MASK_B_MON2_BIT   = 5;
    localparam int MASK_B_MON3_BIT   = 4;
    localparam int MASK_B_MON4_BIT   = 3;
    localparam int MASK_B_MON5_BIT   = 1;

    // Flag vector positions matching mask A
    localparam int FLAG_OV       = 7;
    localparam int FLAG_UV       = 6;
    localparam int FLAG_OCP_TO   = 5;
    localparam int FLAG_AC_LOST  = 4;
    localparam int FLAG_OCP      = 3;
    localparam int FLAG_OTP      = 2;
    localparam int FLAG_ORSW     = 1;
    localparam int FLAG_SHARE    = 0;

    // Fault flags, ordered as the bits of mask A
    typedef struct packed {
        logic overvoltage_fault;
        logic undervoltage_fault;
        logic ocp_timeout;
        logic ac_sense_lost;
        logic overcurrent_flag;
        logic overtemperature;
        logic or_switch_fault;
        logic share_fault;
    } fault_flags_t;

    // Monitor flags, ordered as the used bits of mask B
    typedef struct packed {
        logic supply_not_ok;
        logic monitor_one_flag;
        logic monitor_two_flag;
        logic monitor_three_flag;
        logic monitor_four_flag;
        logic monitor_five_flag;
    } monitor_flags_t;

    // Register port request
    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Power-up load request from the EEPROM sequencer
    typedef struct packed {
        logic       load_en;
        logic [15:0] ee_addr;
        logic [7:0] ee_data;
    } ee_load_t;

endpackage : alert_trim_pkg

// ### alert_trim_props.sv
// Assertions on the alert-select and trim register block
`timescale 1ns/1ps
module alert_trim_props
    import alert_trim_pkg::*;
(
    input wire logic           ref_clk,
    input wire logic           rst_n,
    input wire reg_req_t       reg_req,
    input wire ee_load_t       ee_load,
    input wire monitor_flags_t monitor_flags,
    input wire fault_flags_t   fault_flags,
    input wire logic [7:0]     rdata,
    input wire logic           rvalid,
    input wire logic [7:0]     uv_clamp_code,
    input wire logic [7:0]     output_level_code,
    input wire logic           combined_alert_pin
);
    logic [7:0] ma_reg;
    logic [7:0] mb_reg;
    logic       exp_reg;
    wire        w18 = reg_req.wr_en && reg_req.addr == 8'h18;
    wire        l18 = ee_load.load_en && ee_load.ee_addr == 16'h8118;
    wire        w19 = reg_req.wr_en && reg_req.addr == 8'h19;
    wire        m5 = monitor_flags.monitor_five_flag;
    // Shadow masks; a software write beats a same-cycle copy
    always_ff @(posedge ref_clk) begin
        ma_reg <= !rst_n ? 8'h00 : (reg_req.wr_en && reg_req.addr == 8'h1A)
            ? reg_req.wdata : (ee_load.load_en && ee_load.ee_addr == 16'h811A)
            ? ee_load.ee_data : ma_reg;
        mb_reg <= !rst_n ? 8'h00 : (reg_req.wr_en && reg_req.addr == 8'h1B)
            ? reg_req.wdata : (ee_load.load_en && ee_load.ee_addr == 16'h811B)
            ? ee_load.ee_data : mb_reg;
        exp_reg <= rst_n && (|(ma_reg & fault_flags) | |(mb_reg &
            {monitor_flags[5:1], 1'b1, m5, 1'b0}));
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (reg_req.rd_en |=> rvalid)
        else $error("read got no answer");
    read_idle_a: assert property (!reg_req.rd_en
        |=> !rvalid && $stable(rdata))
        else $error("read answer without request");
    unmapped_zero_a: assert property ((reg_req.rd_en && (reg_req.addr < 8'h18
        || reg_req.addr > 8'h1B)) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    clamp_write_a: assert property (w18
        |=> uv_clamp_code == $past(reg_req.wdata))
        else $error("clamp write lost");
    clamp_copy_a: assert property (l18 && !w18
        |=> uv_clamp_code == $past(ee_load.ee_data))
        else $error("clamp copy lost");
    clamp_hold_a: assert property (!l18 && !w18
        |=> $stable(uv_clamp_code))
        else $error("clamp code moved");
    level_write_a: assert property (w19
        |=> output_level_code == $past(reg_req.wdata))
        else $error("level write lost");
    alert_or_a: assert property (
        combined_alert_pin == exp_reg)
        else $error("alert pin wrong");
    host_drive_a: assert property (mb_reg[2]
        |=> combined_alert_pin)
        else $error("host request ignored");
    unused_bit_a: assert property (ma_reg == 8'h00
        && mb_reg == 8'h01 |=> !combined_alert_pin)
        else $error("unused bit raised alert");
endmodule : alert_trim_props
bind alert_select_and_trim_regs alert_trim_props u_alert_trim_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .ee_load(ee_load),
    .monitor_flags(monitor_flags), .fault_flags(fault_flags), .rdata(rdata),
    .rvalid(rvalid), .uv_clamp_code(uv_clamp_code),
    .output_level_code(output_level_code),
    .combined_alert_pin(combined_alert_pin));

// ### flag_source_model.sv
// Flag source standing in for the fault and monitor circuits
`timescale 1ns/1ps
module flag_source_model
    import alert_trim_pkg::*;
(
    input  wire logic [13:0] level,
    output fault_flags_t     fault_flags,
    output monitor_flags_t   monitor_flags
);
    // Held levels only; a flag that pulsed would hide alert lag
    assign {fault_flags, monitor_flags} = level;
endmodule : flag_source_model
